/* relay_out_consts.vh */
/*
 * Constants for the relay output assignment logic: register offsets,
 * field positions, reset values, source codes and timing.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef RELAY_OUT_CONSTS_VH
`define RELAY_OUT_CONSTS_VH

// Register offsets (byte addresses; per-relay registers as word indices)
`define REG_GLOBAL      8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_MANUAL      8'h10
`define REG_CTRL_WORD   8'h14
`define REG_SER_WORD    8'h18
`define REG_RELAY_BASE  8'h20
`define REG_RELAY_STEP  8'h10
`define REG_RELAY_END   8'h80
`define REG_ASSIGN      2'h0
`define REG_ON_DLY      2'h1
`define REG_HOLD_DLY    2'h2
`define REG_FLAGS       2'h3

// Global register fields
`define GLB_IO_PROFILE  0
`define GLB_BRAKE_EN    1
`define GLB_COMM_ERR    2
`define GLB_FAULT       3

// Relay flag fields
`define FLG_ACT_LOW     0
`define FLG_FALLBACK    1

// Source codes (assignment field, 6 bits)
`define SRC_NONE        6'h00
`define SRC_WARN_G1     6'h01
`define SRC_WARN_G5     6'h05
`define SRC_BRAKE_SEQ   6'h06
`define SRC_HMI_CMD     6'h07
`define SRC_DI_WORD     2'h2
`define SRC_SER_WORD    2'h3
`define WORD_LOW_LAST   4'hA

// Reset values
`define RST_ASSIGN      6'h00
`define RST_DELAY       16'h0000

// Timing: delay unit in microseconds, clock in MHz
`define DLY_UNIT_US     1000
`define CLK_MHZ         25
`define TICK_CYCLES     (`DLY_UNIT_US * `CLK_MHZ)

`endif

/* relay_output_assignment.v */
/*
 * Relay output assignment logic: six relay channels, each picking a
 * source event or control-word bit, with turn-on delay, holding delay,
 * polarity and fallback on error. Registers over a plain strobe port.
 * Assumes external event inputs and straps are asynchronous levels and
 * are synchronised here; control words and error flags are written by
 * software. Event pulses shorter than two clocks may be missed, and
 * relay presence follows the straps three cycles late.
 */
`timescale 1ns/100ps
`include "relay_out_consts.vh"

module relay_output_assignment #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter DLY_W       = 16
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_b,
    // Unit straps
    input  wire        high_power,
    input  wire        expansion_fitted,
    // Events
    input  wire [4:0]  warning_group_source,
    input  wire        brake_seq_cmd,
    input  wire        local_terminal_active,
    // Register port
    input  wire [7:0]  addr,
    input  wire [31:0] wr_data,
    input  wire        wr_stb,
    input  wire        rd_stb,
    output reg  [31:0] rd_data,
    // Outputs
    output reg  [5:0]  relay_out,
    output reg         irq
);

    localparam NR = 6;

    // Event synchronisers
    reg [6:0]  ev_s1_q;
    reg [6:0]  ev_s2_q;
    reg [1:0]  strap_s1_q;
    reg [1:0]  strap_s2_q;
    wire [4:0] warn_s  = ev_s2_q[4:0];
    wire       brake_s = ev_s2_q[5];
    wire       local_s = ev_s2_q[6];

    // Registers
    reg [3:0]       global_q;
    reg [5:0]       manual_q;
    reg [15:0]      ctrl_word_q;
    reg [15:0]      ser_word_q;
    reg [5:0]       irq_stat_q;
    reg [5:0]       irq_mask_q;
    reg [5:0]       assign_q [0:NR-1];
    reg [DLY_W-1:0] on_dly_q [0:NR-1];
    reg [DLY_W-1:0] hold_dly_q [0:NR-1];
    reg [1:0]       flags_q [0:NR-1];

    // Channel state
    reg [NR-1:0]    ev_q;
    reg [NR-1:0]    act_q;
    reg [DLY_W-1:0] tmr_q [0:NR-1];
    reg [NR-1:0]    present_q;
    reg [31:0]      tick_cnt_q;
    reg             tick_q;

    wire io_profile = global_q[`GLB_IO_PROFILE];
    wire brake_en   = global_q[`GLB_BRAKE_EN];
    wire comm_err   = global_q[`GLB_COMM_ERR];

    // Effective source code of one channel
    function [5:0] eff_src;
        input [5:0] code;
        input       brake;
        begin
            if (brake)
                eff_src = `SRC_BRAKE_SEQ;
            else
                eff_src = code;
        end
    endfunction

    // True when the code selects a control-word bit
    function is_word;
        input [5:0] code;
        begin
            is_word = (code[5:4] == `SRC_DI_WORD) || (code[5:4] == `SRC_SER_WORD);
        end
    endfunction

    // Low word bits need the separate I/O profile
    function bit_open;
        input [3:0] bit_pos;
        input       iop;
        begin
            bit_open = iop || (bit_pos > `WORD_LOW_LAST);
        end
    endfunction

    // Event value for one channel
    function ev_val;
        input [5:0]  code;
        input [4:0]  warn;
        input        brake;
        input        loc;
        input [15:0] cw;
        input [15:0] sw;
        input        iop;
        begin
            if (code[5:4] == `SRC_DI_WORD)
                ev_val = cw[code[3:0]] && bit_open(code[3:0], iop);
            else if (code[5:4] == `SRC_SER_WORD)
                ev_val = sw[code[3:0]] && bit_open(code[3:0], iop);
            else if (code >= `SRC_WARN_G1 && code <= `SRC_WARN_G5)
                ev_val = warn[code[2:0] - 3'h1];
            else if (code == `SRC_BRAKE_SEQ)
                ev_val = brake;
            else if (code == `SRC_HMI_CMD)
                ev_val = loc;
            else
                ev_val = 1'b0;
        end
    endfunction

    // Register decode helpers
    wire       in_relay = (addr >= `REG_RELAY_BASE) && (addr < `REG_RELAY_END);
    wire [7:0] rel_off  = addr - `REG_RELAY_BASE;
    wire [2:0] rel_idx  = rel_off[6:4];
    wire [1:0] rel_reg  = rel_off[3:2];

    // Loop indices, one per process
    integer wi;
    integer si;
    integer oi;
    integer ci;

    // Synchronisers and strap capture
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ev_s1_q    <= 7'h00;
            ev_s2_q    <= 7'h00;
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
            present_q  <= 6'h03;
        end
        else
        begin
            ev_s1_q    <= {local_terminal_active, brake_seq_cmd, warning_group_source};
            ev_s2_q    <= ev_s1_q;
            strap_s1_q <= {expansion_fitted, high_power};
            strap_s2_q <= strap_s1_q;
            // Relays one and two are always fitted
            present_q  <= {strap_s2_q[1], strap_s2_q[1], strap_s2_q[1], strap_s2_q[0], 2'h3};
        end
    end

    // Delay tick
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end
        else if (tick_cnt_q >= TICK_CYCLES - 1)
        begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q     <= 1'b0;
        end
    end

    // Register writes
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            global_q    <= 4'h0;
            manual_q    <= 6'h00;
            ctrl_word_q <= 16'h0000;
            ser_word_q  <= 16'h0000;
            irq_mask_q  <= 6'h00;
            for (wi = 0; wi < NR; wi = wi + 1)
            begin
                assign_q[wi]   <= `RST_ASSIGN;
                on_dly_q[wi]   <= `RST_DELAY;
                hold_dly_q[wi] <= `RST_DELAY;
                flags_q[wi]    <= 2'h0;
            end
        end
        else if (wr_stb)
        begin
            case (addr)
                `REG_GLOBAL:    global_q    <= wr_data[3:0];
                `REG_IRQ_MASK:  irq_mask_q  <= wr_data[5:0];
                `REG_MANUAL:    manual_q    <= wr_data[5:0];
                `REG_CTRL_WORD: ctrl_word_q <= wr_data[15:0];
                `REG_SER_WORD:  ser_word_q  <= wr_data[15:0];
                default:
                begin
                    if (in_relay && present_q[rel_idx])
                    begin
                        case (rel_reg)
                            `REG_ASSIGN:   assign_q[rel_idx]   <= wr_data[5:0];
                            `REG_ON_DLY:   on_dly_q[rel_idx]   <= wr_data[DLY_W-1:0];
                            `REG_HOLD_DLY: hold_dly_q[rel_idx] <= wr_data[DLY_W-1:0];
                            default:       flags_q[rel_idx]    <= wr_data[1:0];
                        endcase
                    end
                end
            endcase
        end
    end

    // Channel timing and output
    reg [5:0]      src_w [0:NR-1];
    reg [NR-1:0]   new_ev;
    always @*
    begin
        for (si = 0; si < NR; si = si + 1)
        begin
            src_w[si]  = eff_src(assign_q[si], brake_en);
            new_ev[si] = ev_val(src_w[si], warn_s, brake_s, local_s, ctrl_word_q, ser_word_q, io_profile);
        end
    end

    // Error handling per source kind; absent relays stay off
    reg [NR-1:0] out_d;
    always @*
    begin
        for (oi = 0; oi < NR; oi = oi + 1)
        begin
            if (!present_q[oi])
                out_d[oi] = 1'b0;
            else if (src_w[oi] == `SRC_NONE)
            begin
                if (comm_err && flags_q[oi][`FLG_FALLBACK])
                    out_d[oi] = 1'b0;
                else if (comm_err)
                    out_d[oi] = relay_out[oi];
                else
                    out_d[oi] = manual_q[oi];
            end
            else if (is_word(src_w[oi]) && comm_err)
            begin
                if (flags_q[oi][`FLG_FALLBACK])
                    out_d[oi] = 1'b0;
                else
                    out_d[oi] = relay_out[oi];
            end
            else
                out_d[oi] = act_q[oi] ^ flags_q[oi][`FLG_ACT_LOW];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ev_q      <= 6'h00;
            act_q     <= 6'h00;
            relay_out <= 6'h00;
            for (ci = 0; ci < NR; ci = ci + 1)
                tmr_q[ci] <= `RST_DELAY;
        end
        else
        begin
            relay_out <= out_d;
            // Timer counts ticks while the event differs from the timed state;
            // any change of the event starts the count again
            for (ci = 0; ci < NR; ci = ci + 1)
            begin
                ev_q[ci] <= new_ev[ci];
                if (new_ev[ci] != ev_q[ci])
                    tmr_q[ci] <= `RST_DELAY;
                else if (new_ev[ci] != act_q[ci])
                begin
                    if (new_ev[ci] && tmr_q[ci] >= on_dly_q[ci])
                        act_q[ci] <= 1'b1;
                    else if (!new_ev[ci] && tmr_q[ci] >= hold_dly_q[ci])
                        act_q[ci] <= 1'b0;
                    else if (tick_q)
                        tmr_q[ci] <= tmr_q[ci] + {{(DLY_W-1){1'b0}}, 1'b1};
                end
                else
                    tmr_q[ci] <= `RST_DELAY;
            end
        end
    end

    // Output change events and interrupt
    wire [NR-1:0] out_chg = out_d ^ relay_out;
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_stat_q <= 6'h00;
            irq        <= 1'b0;
        end
        else
        begin
            if (wr_stb && addr == `REG_IRQ_STAT)
                irq_stat_q <= (irq_stat_q & ~wr_data[5:0]) | out_chg;
            else
                irq_stat_q <= irq_stat_q | out_chg;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Register reads; absent and unmapped locations read as zero
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data <= 32'h0000_0000;
        else if (rd_stb)
        begin
            case (addr)
                `REG_GLOBAL:    rd_data <= {28'h0, global_q};
                `REG_STATUS:    rd_data <= {20'h0, present_q, relay_out};
                `REG_IRQ_STAT:  rd_data <= {26'h0, irq_stat_q};
                `REG_IRQ_MASK:  rd_data <= {26'h0, irq_mask_q};
                `REG_MANUAL:    rd_data <= {26'h0, manual_q};
                `REG_CTRL_WORD: rd_data <= {16'h0, ctrl_word_q};
                `REG_SER_WORD:  rd_data <= {16'h0, ser_word_q};
                default:
                begin
                    if (in_relay && present_q[rel_idx])
                    begin
                        case (rel_reg)
                            `REG_ASSIGN:   rd_data <= {26'h0, src_w[rel_idx]};
                            `REG_ON_DLY:   rd_data <= {{(32-DLY_W){1'b0}}, on_dly_q[rel_idx]};
                            `REG_HOLD_DLY: rd_data <= {{(32-DLY_W){1'b0}}, hold_dly_q[rel_idx]};
                            default:       rd_data <= {30'h0, flags_q[rel_idx]};
                        endcase
                    end
                    else
                        rd_data <= 32'h0000_0000;
                end
            endcase
        end
        else
            rd_data <= 32'h0000_0000;
    end

endmodule // relay_output_assignment

/* relay_chk.sv */
/* Port checker for the relay output assignment block.
   Assumes bind to the top module; one clock, reset active low. */
`timescale 1ns/100ps
module relay_chk (
    // Clock and reset
    input wire        ref_clk,
    input wire        rst_b,
    // Straps and bus
    input wire        high_power,
    input wire        expansion_fitted,
    input wire [7:0]  addr,
    input wire        wr_stb,
    input wire        rd_stb,
    input wire [31:0] rd_data,
    // Outputs
    input wire [5:0]  relay_out,
    input wire        irq
);
    reg [5:0] prev_q;
    reg [3:0] quiet_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Cycles since last write or relay change
    always @(posedge ref_clk or negedge rst_b)
        if (!rst_b)
        begin
            prev_q  <= 6'h00;
            quiet_q <= 4'hF;
        end
        else
        begin
            prev_q  <= relay_out;
            quiet_q <= (wr_stb || relay_out != prev_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
        end
    AST_RESET: assert property (disable iff (1'b0) !rst_b |-> relay_out == 6'h00 && !irq)
        else $error("outputs not clear in reset");
    AST_RD_IDLE: assert property (!rd_stb |=> rd_data == 32'h0)
        else $error("read data without read");
    AST_STATUS: assert property (rd_stb && addr == 8'h04 |=> rd_data[7:0] == {2'b11, $past(relay_out)})
        else $error("status read wrong");
    AST_ABS_REG: assert property ((!expansion_fitted)[*6] ##0 (rd_stb && addr >= 8'h50) |=> rd_data == 32'h0)
        else $error("absent relay block readable");
    AST_ABS_HI: assert property ((!expansion_fitted)[*6] |-> relay_out[5:3] == 3'h0)
        else $error("absent relay driven");
    AST_ABS_R3: assert property ((!high_power)[*6] |-> !relay_out[2])
        else $error("relay three driven on small unit");
    AST_IRQ_RISE: assert property ($rose(irq) |-> quiet_q <= 4'h4)
        else $error("interrupt without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_stb) || $past(wr_stb, 2) || $past(wr_stb, 3))
        else $error("interrupt dropped without write");
endmodule // relay_chk
bind relay_output_assignment relay_chk chk_u (.ref_clk, .rst_b, .high_power, .expansion_fitted, .addr,
    .wr_stb, .rd_stb, .rd_data, .relay_out, .irq);

/* relay_load.sv */
/* Model of the loads switched by the relay contacts.
   Assumes coil states from the block; a contact follows one cycle late. */
`timescale 1ns/100ps
module relay_load (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // Coils and contacts
    input  wire [5:0] coil,
    output reg  [5:0] contact
);
    always @(posedge ref_clk or negedge rst_b)
        if (!rst_b)
            contact <= 6'h00;
        else
            contact <= coil;
endmodule // relay_load

/* tb_relay_output_assignment.sv */
/* Self-checking bench for the relay output assignment block.
   Assumes a 25 MHz clock and a short delay tick of 4 cycles. */
`timescale 1ns/100ps
module tb_relay_output_assignment;
    reg         ref_clk, rst_b, high_power, expansion_fitted;
    reg         brake_seq_cmd, local_terminal_active;
    reg  [4:0]  warning_group_source;
    reg  [7:0]  addr;
    reg  [31:0] wr_data, r;
    reg         wr_stb, rd_stb, rd_pend;
    wire [31:0] rd_data;
    wire [5:0]  relay_out, contact;
    wire        irq;
    reg  [5:0]  pres;
    reg  [31:0] expq[$];
    integer     fails, n_checks, cyc, i;

    relay_output_assignment #(.TICK_CYCLES(4)) dut_u (.ref_clk, .rst_b, .high_power, .expansion_fitted,
        .warning_group_source, .brake_seq_cmd, .local_terminal_active, .addr, .wr_data, .wr_stb,
        .rd_stb, .rd_data, .relay_out, .irq);
    relay_load load_u (.ref_clk, .rst_b, .coil(relay_out), .contact);

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp)
            begin
                fails = fails + 1;
                $display("Error %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            addr    <= a;
            wr_data <= d;
            wr_stb  <= 1'b1;
            rd_stb  <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            expq.push_back(e);
            addr   <= a;
            rd_stb <= 1'b1;
            wr_stb <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task idle(input integer n);
        begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            repeat (n) @(posedge ref_clk);
        end
    endtask
    task st(input [5:0] e);
        begin
            rd(8'h04, {20'h0, pres, e});
            chk(contact, e, "contact");
        end
    endtask
    task test_done;
        begin
            $display("checks %0d fails %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    // Read data checked against oldest note
    always @(posedge ref_clk)
    begin
        if (rd_pend)
            chk(rd_data, expq.pop_front(), "rd_data");
        rd_pend <= rd_stb & rst_b;
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            fails = fails + 1;
            test_done;
        end
    end

    initial
    begin
        fails = 0;
        n_checks = 0;
        cyc = 0;
        r = $urandom(32'hA62409D9);
        {rst_b, high_power, expansion_fitted, brake_seq_cmd, local_terminal_active} = 5'h00;
        {warning_group_source, addr, wr_data, wr_stb, rd_stb, rd_pend} = 48'h0;
        pres = 6'h03;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        idle(6);
        st(6'h00);
        wr(8'h50, 32'h21);
        rd(8'h50, 32'h0);
        rd(8'h1C, 32'h0);
        rd(8'h20, 32'h0);
        high_power <= 1'b1;
        expansion_fitted <= 1'b1;
        idle(5);
        pres = 6'h3F;
        st(6'h00);
        rd(8'h50, 32'h0);
        // Manual outputs and error fallback
        wr(8'h2C, 32'h2);
        wr(8'h10, 32'h3);
        idle(4);
        st(6'h03);
        wr(8'h00, 32'h4);
        idle(4);
        st(6'h02);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h0);
        // Control word bits and profile
        wr(8'h20, 32'h21);
        wr(8'h30, 32'h2F);
        wr(8'h14, 32'h8002);
        idle(6);
        st(6'h02);
        wr(8'h00, 32'h1);
        idle(6);
        st(6'h03);
        wr(8'h00, 32'h9);
        idle(6);
        st(6'h03);
        wr(8'h00, 32'h5);
        wr(8'h14, 32'h0);
        idle(6);
        st(6'h02);
        wr(8'h00, 32'h1);
        idle(6);
        st(6'h00);
        wr(8'h40, 32'h35);
        wr(8'h18, 32'h20);
        idle(6);
        st(6'h04);
        wr(8'h18, 32'h0);
        for (i = 1; i <= 5; i = i + 1)
        begin
            wr(8'h50, i);
            r = $urandom;
            warning_group_source <= r[4:0] | (5'h01 << (i - 1));
            idle(8);
            st(6'h08);
            warning_group_source <= r[4:0] & ~(5'h01 << (i - 1));
            idle(8);
            st(6'h00);
        end
        wr(8'h5C, 32'h1);
        idle(8);
        st(6'h08);
        wr(8'h5C, 32'h0);
        wr(8'h50, 32'h0);
        // Turn-on and holding delays of three ticks
        warning_group_source <= 5'h00;
        wr(8'h20, 32'h1);
        wr(8'h24, 32'h3);
        wr(8'h28, 32'h3);
        idle(8);
        warning_group_source <= 5'h01;
        idle(6);
        st(6'h00);
        idle(24);
        st(6'h01);
        warning_group_source <= 5'h00;
        idle(6);
        st(6'h01);
        idle(24);
        st(6'h00);
        for (i = 0; i < 4; i = i + 1)
        begin
            warning_group_source <= i[0] ? 5'h00 : 5'h01;
            idle(6);
        end
        idle(24);
        st(6'h00);
        // Brake sequence and terminal command
        wr(8'h20, 32'h0);
        wr(8'h00, 32'h2);
        brake_seq_cmd <= 1'b1;
        idle(6);
        rd(8'h60, 32'h6);
        idle(24);
        st(6'h3F);
        brake_seq_cmd <= 1'b0;
        wr(8'h00, 32'h0);
        idle(24);
        st(6'h00);
        wr(8'h70, 32'h7);
        wr(8'h08, 32'h3F);
        wr(8'h0C, 32'h20);
        idle(4);
        chk(irq, 0, "irq");
        local_terminal_active <= 1'b1;
        idle(8);
        st(6'h20);
        chk(irq, 1, "irq");
        rd(8'h08, 32'h20);
        wr(8'h0C, 32'h0);
        idle(4);
        chk(irq, 0, "irq");
        wr(8'h0C, 32'h20);
        idle(4);
        chk(irq, 1, "irq");
        wr(8'h08, 32'h20);
        idle(4);
        chk(irq, 0, "irq");
        rd(8'h08, 32'h0);
        local_terminal_active <= 1'b0;
        idle(8);
        st(6'h00);
        idle(4);
        test_done;
    end
endmodule // tb_relay_output_assignment
